/* File: verilog/ckg_top.sv */
// System, peripheral and USB clock generators with their register port.
`timescale 1ns/10ps
`default_nettype none
`include "ckg_params.svh"
module ckg_top (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Source clock levels
	input wire logic ref_clk_in,
	input wire ckg_pkg::ckg_src_s src_in,
	// Generated clocks
	output logic sys_clk_out,
	output logic peri_clk_out,
	output logic usb_clk_out
);
	////////////////////////////////////////////////////////////////////////
	// Auxiliary selection is a plain mux, so it may glitch when changed.
	function automatic logic aux_pick(ckg_pkg::ckg_src_s s, logic sysclk,
			logic [2:0] code, ckg_pkg::ckg_gen_e gen);
		logic r;
		r = 1'b0;
		case (gen)
			ckg_pkg::GEN_SYS:
				case (code)
					3'h0: r = s.pll_sys;
					3'h1: r = s.pll_usb;
					3'h2: r = s.ring_osc;
					3'h3: r = s.xosc;
					3'h4: r = s.general_input0_source;
					3'h5: r = s.general_input1_source;
					default: r = 1'b0;
				endcase
			ckg_pkg::GEN_PERI:
				case (code)
					3'h0: r = sysclk;
					3'h1: r = s.pll_sys;
					3'h2: r = s.pll_usb;
					3'h3: r = s.ring_osc_phased_source;
					3'h4: r = s.xosc;
					3'h5: r = s.general_input0_source;
					3'h6: r = s.general_input1_source;
					default: r = 1'b0;
				endcase
			default:
				case (code)
					3'h0: r = s.pll_usb;
					3'h1: r = s.pll_sys;
					3'h2: r = s.ring_osc_phased_source;
					3'h3: r = s.xosc;
					3'h4: r = s.general_input0_source;
					3'h5: r = s.general_input1_source;
					default: r = 1'b0;
				endcase
		endcase
		return r;
	endfunction : aux_pick

	////////////////////////////////////////////////////////////////////////
	// Register file.
	logic [31:0] sys_ctrl_r, sys_ctrl_nxt, sys_div_r, sys_div_nxt;
	logic [31:0] peri_ctrl_r, peri_ctrl_nxt, usb_ctrl_r, usb_ctrl_nxt;
	logic [31:0] rdata_r, rdata_nxt, sys_status;
	logic main_sel_r, main_sel_nxt;
	assign sys_status = main_sel_r ? 32'h0000_0002 : `CKG_SEL_RST;
	always_comb begin
		sys_ctrl_nxt = sys_ctrl_r;
		sys_div_nxt = sys_div_r;
		peri_ctrl_nxt = peri_ctrl_r;
		usb_ctrl_nxt = usb_ctrl_r;
		rdata_nxt = 32'h0000_0000;
		if (reg_wr) begin
			case (reg_addr)
				`CKG_OFS_SYS_CTRL: sys_ctrl_nxt = reg_wdata & `CKG_SYS_CTRL_MASK;
				`CKG_OFS_SYS_DIV: sys_div_nxt = reg_wdata;
				`CKG_OFS_PERI_CTRL: peri_ctrl_nxt = reg_wdata & `CKG_PERI_CTRL_MASK;
				`CKG_OFS_USB_CTRL: usb_ctrl_nxt = reg_wdata & `CKG_USB_CTRL_MASK;
				default: ;
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				`CKG_OFS_SYS_CTRL: rdata_nxt = sys_ctrl_r;
				`CKG_OFS_SYS_DIV: rdata_nxt = sys_div_r;
				`CKG_OFS_SYS_SEL: rdata_nxt = sys_status;
				`CKG_OFS_PERI_CTRL: rdata_nxt = peri_ctrl_r;
				`CKG_OFS_PERI_SEL: rdata_nxt = `CKG_SEL_RST;
				`CKG_OFS_USB_CTRL: rdata_nxt = usb_ctrl_r;
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			sys_ctrl_r <= `CKG_CTRL_RST;
			sys_div_r <= `CKG_DIV_RST;
			peri_ctrl_r <= `CKG_CTRL_RST;
			usb_ctrl_r <= `CKG_CTRL_RST;
			rdata_r <= 32'h0000_0000;
		end else begin
			sys_ctrl_r <= sys_ctrl_nxt;
			sys_div_r <= sys_div_nxt;
			peri_ctrl_r <= peri_ctrl_nxt;
			usb_ctrl_r <= usb_ctrl_nxt;
			rdata_r <= rdata_nxt;
		end
	end
	assign reg_rdata = rdata_r;

	////////////////////////////////////////////////////////////////////////
	// System generator: glitchless main switch, then fractional divider.
	logic sys_aux, sys_cur, sys_new, sys_prev_r, sys_prev_nxt, sys_rise;
	logic sys_out_r, sys_out_nxt, sys_wrap;
	logic [24:0] sys_cnt_r, sys_cnt_nxt, sys_per_r, sys_per_nxt, int_eff;
	logic [7:0] sys_acc_r, sys_acc_nxt;
	logic [8:0] acc_sum;
	always_comb begin
		sys_aux = aux_pick(src_in, 1'b0,
			sys_ctrl_r[`CKG_AUX_MSB:`CKG_AUX_LSB], ckg_pkg::GEN_SYS);
		sys_cur = main_sel_r ? sys_aux : ref_clk_in;
		sys_new = sys_ctrl_r[`CKG_SRC_BIT] ? sys_aux : ref_clk_in;
		main_sel_nxt = main_sel_r;
		// Both inputs low means no partial pulse can leave the switch.
		if (sys_ctrl_r[`CKG_SRC_BIT] != main_sel_r && !sys_cur && !sys_new)
			main_sel_nxt = sys_ctrl_r[`CKG_SRC_BIT];
		sys_prev_nxt = sys_cur;
		sys_rise = sys_cur & ~sys_prev_r;
		int_eff = (sys_div_r[`CKG_INT_MSB:`CKG_INT_LSB] == 24'h00_0000) ?
			`CKG_INT_ZERO_PERIOD :
			{1'b0, sys_div_r[`CKG_INT_MSB:`CKG_INT_LSB]};
		acc_sum = {1'b0, sys_acc_r} +
			{1'b0, sys_div_r[`CKG_FRACTION_MSB:`CKG_FRACTION_LSB]};
		sys_wrap = (sys_cnt_r + 25'h000_0001) >= sys_per_r;
		sys_cnt_nxt = sys_cnt_r;
		sys_per_nxt = sys_per_r;
		sys_acc_nxt = sys_acc_r;
		if (sys_rise) begin
			if (sys_wrap) begin
				// A new ratio is taken at each period start.
				sys_cnt_nxt = 25'h000_0000;
				sys_acc_nxt = acc_sum[7:0];
				sys_per_nxt = int_eff + {24'h00_0000, acc_sum[8]};
			end else begin
				sys_cnt_nxt = sys_cnt_r + 25'h000_0001;
			end
		end
		if (sys_per_nxt == `CKG_PERIOD_RST)
			sys_out_nxt = sys_cur;
		else
			sys_out_nxt = sys_cnt_nxt < ((sys_per_nxt + 25'h000_0001) >> 1);
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			main_sel_r <= 1'b0;
			sys_prev_r <= 1'b0;
			sys_cnt_r <= 25'h000_0000;
			sys_per_r <= `CKG_PERIOD_RST;
			sys_acc_r <= 8'h00;
			sys_out_r <= 1'b0;
		end else begin
			main_sel_r <= main_sel_nxt;
			sys_prev_r <= sys_prev_nxt;
			sys_cnt_r <= sys_cnt_nxt;
			sys_per_r <= sys_per_nxt;
			sys_acc_r <= sys_acc_nxt;
			sys_out_r <= sys_out_nxt;
		end
	end
	assign sys_clk_out = sys_out_r;

	////////////////////////////////////////////////////////////////////////
	// Peripheral generator: a pulse starts only on an input rise and ends
	// with the input or at once on kill, so enable never cuts one short.
	logic peri_lvl, peri_prev_r, peri_out_r, peri_out_nxt, peri_kill;

	always_comb begin
		peri_lvl = aux_pick(src_in, sys_out_r,
			peri_ctrl_r[`CKG_AUX_MSB:`CKG_AUX_LSB], ckg_pkg::GEN_PERI);
		peri_kill = peri_ctrl_nxt[`CKG_KILL_BIT];
		if (peri_kill)
			peri_out_nxt = 1'b0;
		else if (peri_out_r)
			peri_out_nxt = peri_lvl;
		else
			peri_out_nxt = peri_lvl & ~peri_prev_r &
				peri_ctrl_r[`CKG_EN_BIT];
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			peri_prev_r <= 1'b0;
			peri_out_r <= 1'b0;
		end else begin
			peri_prev_r <= peri_lvl;
			peri_out_r <= peri_out_nxt;
		end
	end
	assign peri_clk_out = peri_out_r;

	////////////////////////////////////////////////////////////////////////
	// USB generator: delayed enable, phase step and clean gating.
	ckg_pkg::ckg_usb_e usb_st_r, usb_st_nxt;
	logic usb_lvl, usb_prev_r, usb_rise, usb_kill, usb_en;
	logic usb_out_r, usb_out_nxt, usb_skip_r, usb_skip_nxt;
	logic usb_step_r, usb_step_nxt;
	logic [1:0] usb_phase_r, usb_phase_nxt, usb_cnt_r, usb_cnt_nxt;

	always_comb begin
		usb_lvl = aux_pick(src_in, 1'b0,
			usb_ctrl_r[`CKG_AUX_MSB:`CKG_AUX_LSB], ckg_pkg::GEN_USB);
		usb_rise = usb_lvl & ~usb_prev_r;
		usb_kill = usb_ctrl_nxt[`CKG_KILL_BIT];
		usb_en = usb_ctrl_r[`CKG_EN_BIT];
		usb_st_nxt = usb_st_r;
		usb_phase_nxt = usb_phase_r;
		usb_cnt_nxt = usb_cnt_r;
		usb_step_nxt = usb_ctrl_r[`CKG_STEP_BIT];
		usb_skip_nxt = usb_skip_r;
		case (usb_st_r)
			ckg_pkg::USB_OFF: begin
				if (usb_en && !usb_kill) begin
					// The delay is caught here; later writes do nothing.
					usb_phase_nxt = usb_ctrl_r[`CKG_PHASE_MSB:`CKG_PHASE_LSB];
					usb_cnt_nxt = 2'h0;
					usb_st_nxt = (usb_phase_nxt == 2'h0) ?
						ckg_pkg::USB_RUN : ckg_pkg::USB_WAIT;
				end
			end
			ckg_pkg::USB_WAIT: begin
				if (!usb_en || usb_kill)
					usb_st_nxt = ckg_pkg::USB_OFF;
				else if (usb_rise) begin
					usb_cnt_nxt = usb_cnt_r + 2'h1;
					if (usb_cnt_nxt == usb_phase_r)
						usb_st_nxt = ckg_pkg::USB_RUN;
				end
			end
			ckg_pkg::USB_RUN: begin
				if (!usb_en || usb_kill)
					usb_st_nxt = ckg_pkg::USB_OFF;
			end
			default: usb_st_nxt = ckg_pkg::USB_OFF;
		endcase
		if (usb_kill)
			usb_out_nxt = 1'b0;
		else if (usb_out_r)
			usb_out_nxt = usb_lvl;
		else
			usb_out_nxt = usb_rise && usb_st_r == ckg_pkg::USB_RUN &&
				!usb_skip_r;
		// A pending step swallows one whole input cycle.
		if (!usb_out_r && usb_rise && usb_skip_r &&
				usb_st_r == ckg_pkg::USB_RUN)
			usb_skip_nxt = 1'b0;
		// A step that lands on a swallow stays pending, so the set comes last.
		if (usb_step_r != usb_ctrl_r[`CKG_STEP_BIT])
			usb_skip_nxt = 1'b1;
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			usb_st_r <= ckg_pkg::USB_OFF;
			usb_prev_r <= 1'b0;
			usb_out_r <= 1'b0;
			usb_skip_r <= 1'b0;
			usb_step_r <= 1'b0;
			usb_phase_r <= 2'h0;
			usb_cnt_r <= 2'h0;
		end else begin
			usb_st_r <= usb_st_nxt;
			usb_prev_r <= usb_lvl;
			usb_out_r <= usb_out_nxt;
			usb_skip_r <= usb_skip_nxt;
			usb_step_r <= usb_step_nxt;
			usb_phase_r <= usb_phase_nxt;
			usb_cnt_r <= usb_cnt_nxt;
		end
	end
	assign usb_clk_out = usb_out_r;

	////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	sequence s_div_write;
		reg_wr && reg_addr == `CKG_OFS_SYS_DIV;
	endsequence
	sequence s_sel_read;
		reg_rd && reg_addr == `CKG_OFS_SYS_SEL;
	endsequence
	AST_DIV_ON_FLY: assert property (s_div_write |=>
		sys_div_r == $past(reg_wdata)) else $error("divisor write lost");
	AST_SEL_STATUS: assert property (s_sel_read |=>
		reg_rdata == (32'h0000_0001 << $past(main_sel_r)))
		else $error("selection status wrong");
	AST_MAIN_SWITCH_LOW: assert property ($changed(main_sel_r) |->
		!$past(sys_cur) && !$past(sys_new)) else $error("main switch glitch");
	AST_INT_ZERO: assert property (sys_rise && sys_wrap &&
		sys_div_r[31:8] == 24'h00_0000 |=> sys_per_r >= 25'h001_0000)
		else $error("zero integer not 65536");
	AST_PERI_KILL: assert property (reg_wr &&
		reg_addr == `CKG_OFS_PERI_CTRL && reg_wdata[10] |=> !peri_clk_out)
		else $error("peripheral kill late");
	AST_PERI_CLEAN: assert property ($fell(peri_clk_out) |->
		!$past(peri_lvl) || $past(peri_kill)) else $error("pulse cut");
	AST_USB_DELAY: assert property (usb_st_r == ckg_pkg::USB_WAIT |->
		usb_cnt_r < usb_phase_r && usb_phase_r != 2'h0)
		else $error("enable delay count wrong");
	AST_USB_PHASE_HELD: assert property (usb_st_r != ckg_pkg::USB_OFF &&
		$past(usb_st_r) != ckg_pkg::USB_OFF |-> $stable(usb_phase_r))
		else $error("delay changed while enabled");
	AST_USB_STEP: assert property (usb_skip_r && usb_rise && !usb_out_r &&
		!usb_kill |=> !usb_clk_out) else $error("step did not swallow");
endmodule : ckg_top
`default_nettype wire

/* File: verilog/ckg_params.svh */
// Register offsets, field positions, reset values and counts of the clock generators.
`ifndef CKG_PARAMS_SVH
`define CKG_PARAMS_SVH
`define CKG_OFS_SYS_CTRL 8'h3C
`define CKG_OFS_SYS_DIV 8'h40
`define CKG_OFS_SYS_SEL 8'h44
`define CKG_OFS_PERI_CTRL 8'h48
`define CKG_OFS_PERI_SEL 8'h50
`define CKG_OFS_USB_CTRL 8'h54
`define CKG_SRC_BIT 0
`define CKG_AUX_MSB 7
`define CKG_AUX_LSB 5
`define CKG_KILL_BIT 10
`define CKG_EN_BIT 11
`define CKG_PHASE_MSB 17
`define CKG_PHASE_LSB 16
`define CKG_STEP_BIT 20
`define CKG_INT_MSB 31
`define CKG_INT_LSB 8
`define CKG_FRACTION_MSB 7
`define CKG_FRACTION_LSB 0
`define CKG_SYS_CTRL_MASK 32'h0000_00E1
`define CKG_PERI_CTRL_MASK 32'h0000_0CE0
`define CKG_USB_CTRL_MASK 32'h0013_0CE0
`define CKG_CTRL_RST 32'h0000_0000
`define CKG_DIV_RST 32'h0000_0100
`define CKG_SEL_RST 32'h0000_0001
`define CKG_INT_ZERO_PERIOD 25'h001_0000
`define CKG_PERIOD_RST 25'h000_0001
`endif

/* File: verilog/ckg_pkg.sv */
// Types shared by the clock generator block.
`default_nettype none
package ckg_pkg;
	typedef struct packed {
		logic pll_sys;
		logic pll_usb;
		logic ring_osc;
		logic ring_osc_phased_source;
		logic xosc;
		logic general_input0_source;
		logic general_input1_source;
	} ckg_src_s;
	typedef enum logic [1:0] {GEN_SYS, GEN_PERI, GEN_USB} ckg_gen_e;
	typedef enum logic [1:0] {USB_OFF, USB_WAIT, USB_RUN} ckg_usb_e;
endpackage : ckg_pkg
`default_nettype wire

/* File: verification/ckg_top_tb_top.sv */
// Self-checking testbench of the clock generator block.
`timescale 1ns/10ps
`default_nettype none
`include "ckg_params.svh"
module ckg_top_tb_top;
	logic sys_clk, sys_rst, reg_wr, reg_rd, ref_clk_in;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, d;
	ckg_pkg::ckg_src_s src_in;
	logic sys_clk_out, peri_clk_out, usb_clk_out;
	logic [2:0] outs, prev;
	int rises[3];
	int fail_count, check_count, cyc, seed, pend, ex;
	// Bit of src_in (7 means ref_clk_in) behind each auxiliary code.
	int sys_map[6] = '{6, 5, 4, 2, 1, 0};
	int peri_map[7] = '{7, 6, 5, 3, 2, 1, 0};
	int usb_map[6] = '{5, 6, 3, 2, 1, 0};
	logic [7:0] ra[7] = '{8'h3C, 8'h40, 8'h44, 8'h48, 8'h50, 8'h54, 8'h4C};
	logic [31:0] rv[7] = '{`CKG_CTRL_RST, `CKG_DIV_RST, `CKG_SEL_RST,
		`CKG_CTRL_RST, `CKG_SEL_RST, `CKG_CTRL_RST, 32'h0};
	logic [7:0] wa[4] = '{8'h3C, 8'h40, 8'h48, 8'h54};
	logic [31:0] wm[4] = '{`CKG_SYS_CTRL_MASK, 32'hFFFF_FFFF,
		`CKG_PERI_CTRL_MASK, `CKG_USB_CTRL_MASK};

	ckg_top dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .ref_clk_in(ref_clk_in), .src_in(src_in),
		.sys_clk_out(sys_clk_out), .peri_clk_out(peri_clk_out),
		.usb_clk_out(usb_clk_out));

	assign outs = {usb_clk_out, peri_clk_out, sys_clk_out};

	always #50 sys_clk = ~sys_clk;

	// Outputs are sampled on the falling edge, away from their update.
	always @(negedge sys_clk) begin
		for (int i = 0; i < 3; i++) begin
			if (outs[i] === 1'b1 && prev[i] !== 1'b1) rises[i]++;
		end
		prev = outs;
	end

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			conclude();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic conclude();
		$display("checks=%0d mismatches=%0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : conclude

	// Bus tasks leave a quiet cycle so no strobe is assigned twice at once.
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		@(posedge sys_clk);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
		@(posedge sys_clk);
	endtask : rd

	function automatic logic [31:0] ctl(input int en, input int dl,
		input int c);
		return (en != 0 ? 32'h0000_0800 : 32'h0) | (32'(dl) << 16)
			| (32'(c) << 5);
	endfunction : ctl

	task automatic drv(input int bi, input logic v);
		if (bi == 7) ref_clk_in <= v;
		else src_in <= ckg_pkg::ckg_src_s'(7'(v) << bi);
	endtask : drv

	// Sends n source pulses, two cycles high and two low, counts output rises.
	task automatic train(input int bi, input int n, input int w,
		input int ex);
		int r0;
		r0 = rises[w];
		repeat (n) begin
			drv(bi, 1'b1);
			repeat (2) @(posedge sys_clk);
			drv(bi, 1'b0);
			repeat (2) @(posedge sys_clk);
		end
		repeat (4) @(posedge sys_clk);
		chk(32'(rises[w] - r0), 32'(ex));
	endtask : train

	////////////////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		sys_rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		ref_clk_in = 1'b0;
		src_in = '0;
		prev = 3'h0;
		seed = 32'hE3B6CDD4;
		pend = 0;
		repeat (20) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		for (int i = 0; i < 7; i++) rd(ra[i], rv[i]);
		repeat (2) begin
			for (int i = 0; i < 4; i++) begin
				d = $random(seed);
				wr(wa[i], d);
				rd(wa[i], d & wm[i]);
				// A step bit toggled here leaves one USB pulse to swallow.
				if (i == 3 && d[20]) pend = 1;
			end
			// Restore first, so the main switch is back on the reference.
			for (int i = 0; i < 4; i++) wr(wa[i], rv[i == 1 ? 1 : 0]);
			wr(8'h44, d);
			rd(8'h44, `CKG_SEL_RST);
			wr(8'h4C, d);
			rd(8'h4C, 32'h0);
		end
		// The main switch is moved off the auxiliary path before each change.
		for (int c = 0; c < 6; c++) begin
			wr(8'h3C, ctl(0, 0, c));
			wr(8'h3C, ctl(0, 0, c) | 32'h1);
			repeat (4) @(posedge sys_clk);
			rd(8'h44, 32'h2);
			train(sys_map[c], 3, 0, 3);
			wr(8'h3C, ctl(0, 0, c));
		end
		rd(8'h44, 32'h1);
		train(7, 3, 0, 3);
		wr(8'h40, 32'h0000_0300);
		train(7, 12, 0, 4);
		wr(8'h40, 32'h0000_0280);
		train(7, 10, 0, 4);
		wr(8'h40, `CKG_DIV_RST);
		for (int c = 0; c < 7; c++) begin
			wr(8'h48, ctl(1, 0, c));
			train(peri_map[c], 3, 1, 3);
			wr(8'h48, 32'h0);
		end
		train(6, 3, 1, 0);
		wr(8'h48, ctl(1, 0, 1) | 32'h0000_0400);
		train(6, 3, 1, 0);
		wr(8'h48, 32'h0);
		for (int c = 0; c < 6; c++) begin
			wr(8'h54, ctl(0, c % 4, c));
			wr(8'h54, ctl(1, c % 4, c));
			ex = 6 - c % 4 - (c == 0 ? pend : 0);
			train(usb_map[c], 6, 2, ex);
			wr(8'h54, 32'h0);
		end
		wr(8'h54, ctl(1, 0, 0));
		wr(8'h54, ctl(1, 3, 0));
		train(5, 6, 2, 6);
		wr(8'h54, ctl(1, 0, 0));
		train(5, 2, 2, 2);
		wr(8'h54, ctl(1, 0, 0) | 32'h0010_0000);
		train(5, 4, 2, 3);
		wr(8'h54, ctl(1, 0, 0) | 32'h0000_0400);
		train(5, 3, 2, 0);
		// Zero integer means a period of 65536 input cycles, so the output just stays high.
		wr(8'h40, 32'h0000_0000);
		train(7, 4, 0, 1);
		conclude();
	end
endmodule : ckg_top_tb_top
`default_nettype wire
